// ==== rtl/lies_pkg.sv ====
package lies_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int LIES_NUM_CTR = 4;
	localparam int LIES_CLASS_N = 7;
	localparam int LIES_OCC_W   = 6;
	localparam int LIES_INC_W   = 9;
	localparam int LIES_CNT_W   = 32;

	// ----------------------------------------------------------------
	// event codes
	// ----------------------------------------------------------------
	localparam logic [7:0] LIES_EV_VN0_ALLOC = 8'h41;
	localparam logic [7:0] LIES_EV_VN1_ALLOC = 8'h42;
	localparam logic [7:0] LIES_EV_VN0_OCC   = 8'h45;
	localparam logic [7:0] LIES_EV_VN1_OCC   = 8'h46;
	localparam logic [7:0] LIES_EV_VN0_MISS  = 8'h4E;
	localparam logic [7:0] LIES_EV_VN1_MISS  = 8'h4F;

	// ----------------------------------------------------------------
	// message class bit positions in the unit mask
	// ----------------------------------------------------------------
	localparam int LIES_CLS_ADDR_REQ            = 0;
	localparam int LIES_CLS_ADDR_SNOOP          = 1;
	localparam int LIES_CLS_ADDR_RESPONSE       = 2;
	localparam int LIES_CLS_DATA_RESPONSE       = 3;
	localparam int LIES_CLS_DATA_WRITEBACK      = 4;
	localparam int LIES_CLS_DATA_NONCOH_BCAST   = 5;
	localparam int LIES_CLS_DATA_NONCOH_STD     = 6;

	// ----------------------------------------------------------------
	// register map and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  LIES_CTL_BASE    = 8'h00;
	localparam logic [7:0]  LIES_CNT_BASE    = 8'h04;
	localparam logic [7:0]  LIES_CTR_STRIDE  = 8'h08;
	localparam logic [7:0]  LIES_FREEZE_OFS  = 8'h40;
	localparam logic [31:0] LIES_CTL_WMASK   = 32'h0040FFFF;
	localparam logic [31:0] LIES_CTL_RST     = 32'h00000000;
	localparam logic [31:0] LIES_CNT_RST     = 32'h00000000;
	localparam logic        LIES_FREEZE_RST  = 1'b0;
	localparam int          LIES_FREEZE_BIT  = 0;
	localparam logic [1:0]  LIES_HTRANS_NSEQ = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [8:0] rsvd_hi;
		logic       enable;
		logic [5:0] rsvd_mid;
		logic [7:0] umask;
		logic [7:0] event_code;
	} lies_ctl_t;

	typedef struct packed {
		logic [LIES_CLASS_N-1:0]                 alloc;
		logic [LIES_CLASS_N-1:0]                 slot_miss;
		logic [LIES_CLASS_N-1:0][LIES_OCC_W-1:0] occ;
	} lies_vn_ev_t;

endpackage

// ==== rtl/lies_counter.sv ====
`timescale 1ns/10ps
module lies_counter
	import lies_pkg::*;
(
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  wr_en,
	input  wire logic [LIES_CNT_W-1:0] wr_data,
	input  wire logic                  add_en,
	input  wire logic [LIES_INC_W-1:0] inc,
	output logic      [LIES_CNT_W-1:0] count
);

	logic [LIES_CNT_W-1:0] count_reg;
	logic [LIES_CNT_W-1:0] count_next;

	// ----------------------------------------------------------------
	// accumulate
	// ----------------------------------------------------------------
	always_comb
	begin
		count_next = count_reg;
		if (wr_en)
			count_next = wr_data;
		else if (add_en) // [RQ15]
			count_next = count_reg + {{(LIES_CNT_W-LIES_INC_W){1'b0}}, inc};
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			count_reg <= LIES_CNT_RST;
		else
			count_reg <= count_next;
	end

	assign count = count_reg;

	chk_hold_when_off: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ15]
		(!add_en && !wr_en) |=> $stable(count))
		else $error("counter moved while not enabled");

	chk_write_loads: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_en |=> (count == $past(wr_data)))
		else $error("counter write not loaded");

endmodule

// ==== rtl/lies_event_select.sv ====
// Overview of operation
// RQ1: code 41h counts net-zero ingress allocations
// RQ2: code 42h selects net-one ingress events
// RQ3: net-one insert adds each matching allocation
// RQ4: code 45h gives net-zero occupancy
// RQ5: code 46h gives net-one occupancy
// RQ6: occupancy adds matching entry count each cycle
// RQ7: code 4Eh counts net-zero slot misses
// RQ8: code 4Fh counts net-one slot misses
// RQ9: miss means ready message, flit slot empty
// RQ10: every counter selects its event independently
// RQ11: mask bits 15:8; address ring classes 0-2
// RQ12: data ring response, writeback, broadcast bits 3-5
// RQ13: mask bit 6 selects non-coherent standard
// RQ14: several mask bits combine as OR; the code adds the counts of all selected classes
// RQ15: add only when enabled and not frozen
`timescale 1ns/10ps
module lies_event_select
	import lies_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire lies_vn_ev_t vn0_ev,
	input  wire lies_vn_ev_t vn1_ev
);

	// ----------------------------------------------------------------
	// bus slave state
	// ----------------------------------------------------------------
	logic        ap_valid_reg;
	logic        ap_valid_next;
	logic        ap_write_reg;
	logic        ap_write_next;
	logic        ap_hit_reg;
	logic        ap_hit_next;
	logic [7:0]  ap_addr_reg;
	logic [7:0]  ap_addr_next;
	logic [31:0] hrdata_reg;
	logic [31:0] hrdata_next;
	logic        ap_take;
	logic        wr_active;
	logic [31:0] rd_value;

	// ----------------------------------------------------------------
	// control state
	// ----------------------------------------------------------------
	lies_ctl_t             ctl_reg  [LIES_NUM_CTR];
	lies_ctl_t             ctl_next [LIES_NUM_CTR];
	logic                  freeze_reg;
	logic                  freeze_next;
	logic [LIES_NUM_CTR-1:0] cnt_wr;
	logic [LIES_CNT_W-1:0] count_w  [LIES_NUM_CTR];
	logic [LIES_INC_W-1:0] inc_w    [LIES_NUM_CTR];

	// zero-wait slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	// ----------------------------------------------------------------
	// address phase capture and read mux
	// ----------------------------------------------------------------
	assign ap_take   = hsel && (htrans == LIES_HTRANS_NSEQ) && hready;
	assign wr_active = ap_valid_reg && ap_write_reg && ap_hit_reg;

	always_comb
	begin
		rd_value = 32'h00000000;
		if (haddr[31:8] == 24'h000000)
		begin
			if (haddr[7:0] == LIES_FREEZE_OFS)
				rd_value[LIES_FREEZE_BIT] = freeze_reg;
			for (int i = 0; i < LIES_NUM_CTR; i++)
			begin
				if (haddr[7:0] == 8'(LIES_CTL_BASE + LIES_CTR_STRIDE * i))
					rd_value = ctl_reg[i];
				if (haddr[7:0] == 8'(LIES_CNT_BASE + LIES_CTR_STRIDE * i))
					rd_value = count_w[i];
			end
		end
	end

	always_comb
	begin
		ap_valid_next = ap_take;
		ap_write_next = ap_write_reg;
		ap_hit_next   = ap_hit_reg;
		ap_addr_next  = ap_addr_reg;
		hrdata_next   = hrdata_reg;
		if (ap_take)
		begin
			ap_write_next = hwrite;
			ap_hit_next   = (haddr[31:8] == 24'h000000) && (hsize == 3'h2);
			ap_addr_next  = haddr[7:0];
			if (!hwrite)
				hrdata_next = rd_value;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ap_valid_reg <= 1'b0;
			ap_write_reg <= 1'b0;
			ap_hit_reg   <= 1'b0;
			ap_addr_reg  <= 8'h00;
			hrdata_reg   <= 32'h00000000;
		end
		else
		begin
			ap_valid_reg <= ap_valid_next;
			ap_write_reg <= ap_write_next;
			ap_hit_reg   <= ap_hit_next;
			ap_addr_reg  <= ap_addr_next;
			hrdata_reg   <= hrdata_next;
		end
	end

	// ----------------------------------------------------------------
	// register writes in the data phase
	// ----------------------------------------------------------------
	always_comb
	begin
		freeze_next = freeze_reg;
		cnt_wr      = '0;
		if (wr_active && (ap_addr_reg == LIES_FREEZE_OFS))
			freeze_next = hwdata[LIES_FREEZE_BIT];
		for (int i = 0; i < LIES_NUM_CTR; i++)
		begin
			ctl_next[i] = ctl_reg[i];
			if (wr_active && (ap_addr_reg == 8'(LIES_CTL_BASE + LIES_CTR_STRIDE * i)))
				ctl_next[i] = hwdata & LIES_CTL_WMASK; // [RQ11]
			if (wr_active && (ap_addr_reg == 8'(LIES_CNT_BASE + LIES_CTR_STRIDE * i)))
				cnt_wr[i] = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			freeze_reg <= LIES_FREEZE_RST;
			for (int i = 0; i < LIES_NUM_CTR; i++)
				ctl_reg[i] <= LIES_CTL_RST;
		end
		else
		begin
			freeze_reg <= freeze_next;
			for (int i = 0; i < LIES_NUM_CTR; i++)
				ctl_reg[i] <= ctl_next[i];
		end
	end

	chk_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
		hreadyout && !hresp)
		else $error("slave not ready or not okay");

	chk_ctl_reserved: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ11]
		(wr_active && (ap_addr_reg == LIES_CTL_BASE)) |=> (ctl_reg[0] == ($past(hwdata) & LIES_CTL_WMASK)))
		else $error("control write not stored under mask");

	// ----------------------------------------------------------------
	// bus side checks
	// ----------------------------------------------------------------
	chk_freeze_store: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ15]
		(wr_active && (ap_addr_reg == LIES_FREEZE_OFS)) |=> (freeze_reg == $past(hwdata[LIES_FREEZE_BIT])))
		else $error("freeze write not stored");

	chk_unmapped_read: assert property (@(posedge hclk) disable iff (!hresetn)
		(ap_take && !hwrite && (haddr[31:8] != 24'h000000)) |=> (hrdata == 32'h00000000))
		else $error("unmapped read not zero");

	chk_read_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		(!ap_take) |=> $stable(hrdata))
		else $error("read data moved without a read");

	// ----------------------------------------------------------------
	// per-counter event selection
	// ----------------------------------------------------------------
	for (genvar g = 0; g < LIES_NUM_CTR; g++)
	begin : gen_ctr
		logic [LIES_CLASS_N-1:0] cls;
		logic [LIES_CLASS_N-1:0] m0_alloc;
		logic [LIES_CLASS_N-1:0] m1_alloc;
		logic [LIES_CLASS_N-1:0] m0_miss;
		logic [LIES_CLASS_N-1:0] m1_miss;
		logic [LIES_INC_W-1:0]   inc;
		logic                    add_en;
		logic                    known;
		logic [7:0]              code;

		// bits 0-2 address ring, 3-5 data ring, 6 non-coherent standard
		assign cls      = ctl_reg[g].umask[LIES_CLASS_N-1:0]; // [RQ11] [RQ12] [RQ13]
		assign code     = ctl_reg[g].event_code;
		assign m0_alloc = vn0_ev.alloc & cls;
		assign m1_alloc = vn1_ev.alloc & cls;
		assign m0_miss  = vn0_ev.slot_miss & cls;
		assign m1_miss  = vn1_ev.slot_miss & cls;
		assign add_en   = ctl_reg[g].enable && !freeze_reg; // [RQ15]
		assign known    = (code == LIES_EV_VN0_ALLOC) || (code == LIES_EV_VN1_ALLOC) ||
				  (code == LIES_EV_VN0_OCC) || (code == LIES_EV_VN1_OCC) ||
				  (code == LIES_EV_VN0_MISS) || (code == LIES_EV_VN1_MISS);

		// each counter decodes its own control word [RQ10]
		always_comb
		begin
			inc = '0;
			for (int c = 0; c < LIES_CLASS_N; c++)
			begin
				// any selected class contributes [RQ14]
				if (cls[c])
				begin
					unique case (code)
						LIES_EV_VN0_ALLOC: inc = inc + {8'h00, vn0_ev.alloc[c]};     // [RQ1]
						LIES_EV_VN1_ALLOC: inc = inc + {8'h00, vn1_ev.alloc[c]};     // [RQ2] [RQ3]
						LIES_EV_VN0_OCC:   inc = inc + {3'h0, vn0_ev.occ[c]};        // [RQ4] [RQ6]
						LIES_EV_VN1_OCC:   inc = inc + {3'h0, vn1_ev.occ[c]};        // [RQ5] [RQ6]
						// miss strobe: ready message, flit sent with slot empty
						LIES_EV_VN0_MISS:  inc = inc + {8'h00, vn0_ev.slot_miss[c]}; // [RQ7] [RQ9]
						LIES_EV_VN1_MISS:  inc = inc + {8'h00, vn1_ev.slot_miss[c]}; // [RQ8] [RQ9]
						default:           inc = inc;
					endcase
				end
			end
		end

		assign inc_w[g] = inc;

		lies_counter u_counter (
			.hclk    (hclk),
			.hresetn (hresetn),
			.wr_en   (cnt_wr[g]),
			.wr_data (hwdata),
			.add_en  (add_en),
			.inc     (inc_w[g]),
			.count   (count_w[g])
		);

		chk_vn0_alloc_sum: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ1]
			(code == LIES_EV_VN0_ALLOC && add_en && !cnt_wr[g])
			|=> (count_w[g] == $past(count_w[g]) + 32'($countones($past(m0_alloc)))))
			else $error("net-zero allocation count wrong");

		chk_vn1_alloc_sum: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ3]
			(code == LIES_EV_VN1_ALLOC && add_en && !cnt_wr[g])
			|=> (count_w[g] == $past(count_w[g]) + 32'($countones($past(m1_alloc)))))
			else $error("net-one allocation count wrong");

		chk_vn0_occ_req: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ6]
			(code == LIES_EV_VN0_OCC && ctl_reg[g].umask == 8'h01 && add_en && !cnt_wr[g])
			|=> (count_w[g] == $past(count_w[g]) + 32'($past(vn0_ev.occ[LIES_CLS_ADDR_REQ]))))
			else $error("net-zero occupancy not accumulated");

		chk_vn1_occ_ncs: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ5]
			(code == LIES_EV_VN1_OCC && ctl_reg[g].umask == 8'h40 && add_en && !cnt_wr[g])
			|=> (count_w[g] == $past(count_w[g]) + 32'($past(vn1_ev.occ[LIES_CLS_DATA_NONCOH_STD]))))
			else $error("net-one occupancy not accumulated");

		chk_vn0_miss_sum: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ7]
			(code == LIES_EV_VN0_MISS && add_en && !cnt_wr[g])
			|=> (count_w[g] == $past(count_w[g]) + 32'($countones($past(m0_miss)))))
			else $error("net-zero slot miss count wrong");

		chk_vn1_miss_sum: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ8]
			(code == LIES_EV_VN1_MISS && add_en && !cnt_wr[g])
			|=> (count_w[g] == $past(count_w[g]) + 32'($countones($past(m1_miss)))))
			else $error("net-one slot miss count wrong");

		chk_unknown_code: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ10]
			(!known && !cnt_wr[g]) |=> $stable(count_w[g]))
			else $error("counter moved on unknown code");

		chk_freeze_hold: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ15]
			(freeze_reg && !cnt_wr[g]) [*2] |-> $stable(count_w[g]))
			else $error("counter moved while frozen");

		chk_disabled_hold: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ15]
			(!ctl_reg[g].enable && !cnt_wr[g]) |=> $stable(count_w[g]))
			else $error("counter moved while disabled");

		chk_write_wins: assert property (@(posedge hclk) disable iff (!hresetn)
			cnt_wr[g] |=> (count_w[g] == $past(hwdata)))
			else $error("counter write lost to increment");

		chk_pulse_limit: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ14]
			((code == LIES_EV_VN0_ALLOC) || (code == LIES_EV_VN1_ALLOC) ||
			 (code == LIES_EV_VN0_MISS) || (code == LIES_EV_VN1_MISS)) |-> (inc <= 9'h007))
			else $error("pulse increment above class count");

		chk_empty_mask: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ11]
			((cls == '0) && !cnt_wr[g]) |=> $stable(count_w[g]))
			else $error("counter moved with empty mask");
	end

endmodule

// ==== verification/lies_ingress_model.sv ====
`timescale 1ns/10ps
module lies_ingress_model
	import lies_pkg::*;
(
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  act,
	input  wire logic                  net,
	input  wire logic [LIES_CLASS_N-1:0] alloc,
	input  wire logic [LIES_CLASS_N-1:0] miss,
	input  wire logic [LIES_OCC_W-1:0]   occ,
	output lies_vn_ev_t                vn0_ev,
	output lies_vn_ev_t                vn1_ev
);
	lies_vn_ev_t ev;
	lies_vn_ev_t vn0_next;
	lies_vn_ev_t vn1_next;

	// ----------------------------------------------------------------
	// queue activity, idle queues are empty and quiet
	// ----------------------------------------------------------------
	always_comb
	begin
		ev.alloc     = alloc;
		ev.slot_miss = miss;
		for (int c = 0; c < LIES_CLASS_N; c++)
			ev.occ[c] = occ + LIES_OCC_W'(c);
		vn0_next = (act && !net) ? ev : '0;
		vn1_next = (act && net) ? ev : '0;
	end

	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			vn0_ev <= '0;
			vn1_ev <= '0;
		end
		else
		begin
			vn0_ev <= vn0_next;
			vn1_ev <= vn1_next;
		end
endmodule

// ==== verification/link_ingress_event_select_test.sv ====
`timescale 1ns/10ps
module link_ingress_event_select_test;
	import lies_pkg::*;
	typedef struct packed {
		logic [7:0] code;
		logic [7:0] umask;
		logic       net;
		logic [6:0] alloc;
		logic [6:0] miss;
		logic [5:0] occ;
	} lies_row_t;

	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, act, net;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0]  htrans;
	logic [6:0]  alloc, miss;
	logic [5:0]  occ;
	lies_vn_ev_t vn0_ev, vn1_ev;
	int          error_cnt, checks_done;
	lies_row_t   rows [9] = '{
		'{8'h45, 8'h01, 1'b0, 7'h00, 7'h00, 6'h07},
		'{8'h41, 8'h01, 1'b0, 7'h01, 7'h00, 6'h00}, '{8'h42, 8'h7F, 1'b1, 7'h55, 7'h00, 6'h00},
		'{8'h45, 8'h05, 1'b0, 7'h00, 7'h00, 6'h02}, '{8'h46, 8'h40, 1'b1, 7'h00, 7'h00, 6'h09},
		'{8'h4E, 8'h38, 1'b0, 7'h00, 7'h18, 6'h00}, '{8'h4F, 8'h06, 1'b1, 7'h00, 7'h07, 6'h00},
		'{8'h41, 8'h7F, 1'b1, 7'h7F, 7'h7F, 6'h05}, '{8'h43, 8'hFF, 1'b0, 7'h7F, 7'h7F, 6'h05}};

	assign hready = hreadyout;
	lies_event_select dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .vn0_ev(vn0_ev), .vn1_ev(vn1_ev));
	lies_ingress_model far (.hclk(hclk), .hresetn(hresetn), .act(act), .net(net), .alloc(alloc),
		.miss(miss), .occ(occ), .vn0_ev(vn0_ev), .vn1_ev(vn1_ev));

	initial
	begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	// ----------------------------------------------------------------
	// bus master, comparison and stimulus
	// ----------------------------------------------------------------
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= LIES_HTRANS_NSEQ;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic run(input lies_row_t r, input int n);
		@(posedge hclk);
		act   <= 1'b1;
		net   <= r.net;
		alloc <= r.alloc;
		miss  <= r.miss;
		occ   <= r.occ;
		repeat (n) @(posedge hclk);
		act <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask

	function automatic logic [31:0] lies_inc(input lies_row_t r);
		logic [31:0] s;
		s = 32'h0;
		for (int c = 0; c < 7; c++)
			if (r.umask[c])
			begin
				if (r.code == (r.net ? LIES_EV_VN1_ALLOC : LIES_EV_VN0_ALLOC)) s += r.alloc[c];
				if (r.code == (r.net ? LIES_EV_VN1_MISS : LIES_EV_VN0_MISS)) s += r.miss[c];
				if (r.code == (r.net ? LIES_EV_VN1_OCC : LIES_EV_VN0_OCC)) s += r.occ + c;
			end
		return s;
	endfunction

	task automatic results();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		#200us;
		error_cnt++;
		results();
	end

	initial
	begin
		{hresetn, hsel, hwrite, act, net, alloc, miss, occ} = '0;
		{haddr, hwdata, htrans, error_cnt, checks_done} = '0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, 32'h0, 32'h0);
		chk("ctl0 reset", LIES_CTL_RST, q);
		ahb(1'b0, 32'h4, 32'h0);
		chk("cnt0 reset", LIES_CNT_RST, q);
		foreach (rows[i])
		begin
			ahb(1'b1, 32'h0, {9'h0, 1'b1, 6'h0, rows[i].umask, rows[i].code});
			ahb(1'b1, 32'h4, 32'h0);
			run(rows[i], 3);
			ahb(1'b0, 32'h4, 32'h0);
			chk("count row", 3 * lies_inc(rows[i]), q);
		end
		// three counters watching one queue at once
		ahb(1'b1, 32'h0, 32'h00400141);
		ahb(1'b1, 32'h8, 32'h00400245);
		ahb(1'b1, 32'h10, 32'h0040014E);
		for (int n = 0; n < 3; n++) ahb(1'b1, 32'h4 + 8 * n, 32'h0);
		run('{8'h0, 8'h0, 1'b0, 7'h01, 7'h01, 6'h03}, 3);
		ahb(1'b0, 32'h4, 32'h0);
		chk("cnt0 shared", 32'h3, q);
		ahb(1'b0, 32'hC, 32'h0);
		chk("cnt1 shared", 32'hC, q);
		ahb(1'b0, 32'h14, 32'h0);
		chk("cnt2 shared", 32'h3, q);
		// frozen, then disabled: no counting
		ahb(1'b1, {24'h0, LIES_FREEZE_OFS}, 32'h1);
		ahb(1'b1, 32'h4, 32'h0);
		run('{8'h0, 8'h0, 1'b0, 7'h01, 7'h00, 6'h00}, 4);
		ahb(1'b0, 32'h4, 32'h0);
		chk("cnt0 frozen", 32'h0, q);
		ahb(1'b1, {24'h0, LIES_FREEZE_OFS}, 32'h0);
		ahb(1'b1, 32'h0, 32'h00000141);
		run('{8'h0, 8'h0, 1'b0, 7'h01, 7'h00, 6'h00}, 4);
		ahb(1'b0, 32'h4, 32'h0);
		chk("cnt0 disabled", 32'h0, q);
		ahb(1'b0, 32'h100, 32'h0);
		chk("unmapped read", 32'h0, q);
		chk("bus response", 32'h0, {31'h0, hresp});
		results();
	end
endmodule
